//--- rtl/burst_defines.svh
// Named constants for the four-word burst memory port.
// Assumes inclusion by bare name from the package, compiled ahead of the design modules.
`ifndef BURST_DEFINES_SVH
`define BURST_DEFINES_SVH

`define SYNC_STAGES      3
`define BURST_LEN        4
`define BEAT_W           2
`define BEAT_LAST        2'h3
`define BEAT_FIRST       2'h0
`define BEAT_SECOND      2'h1
`define LAT_CNT_W        2
`define LAT_PLL_EDGES    2'h3
`define LAT_BYPASS_EDGES 2'h2
`define LAT_CNT_ONE      2'h1
`define LANE_W_BYTE      9
`define LANE_W_NIBBLE    4
`define NIBBLE_DATA_W    8
`define NARROW_DATA_W    9
`define MID_DATA_W       18
`define AW_NARROW        20
`define AW_MID           19
`define AW_WIDE          18
`define NIBBLE_SEL_W     2
`define BYTE_SEL_W       4
`define STORE_AW         4
`define CLK_W            4
`define CTL_W            8
`define BIT_KP           0
`define BIT_KN           1
`define BIT_CP           2
`define BIT_CN           3
`define BIT_WSEL         4
`define BIT_RSEL         5
`define BIT_PLLN         6
`define BIT_SINGLE       7
`define CTL_RESET        8'h7a
`define CLK_RESET        4'ha

`endif

//--- rtl/burst_pkg.sv
// Types and width functions shared by the burst memory port modules.
// Assumes burst_defines.svh is on the include path.
`include "burst_defines.svh"

package burst_pkg;

  typedef logic [`BEAT_W-1:0] beat_t;

  typedef enum logic [1:0] {
    WR_IDLE,
    WR_BEAT1,
    WR_BEAT2,
    WR_BEAT3
  } wr_state_e;

  typedef enum logic [1:0] {
    OUT_IDLE,
    OUT_DRIVE,
    OUT_HOLD
  } out_state_e;

  function automatic int lane_w(input int dataW);
    return (dataW == `NIBBLE_DATA_W) ? `LANE_W_NIBBLE : `LANE_W_BYTE;
  endfunction : lane_w

  function automatic int lane_count(input int dataW);
    return dataW / lane_w(dataW);
  endfunction : lane_count

  function automatic int addr_w(input int dataW);
    if (dataW <= `NARROW_DATA_W) begin
      return `AW_NARROW;
    end
    return (dataW == `MID_DATA_W) ? `AW_MID : `AW_WIDE;
  endfunction : addr_w

endpackage : burst_pkg

//--- rtl/mem_if.sv
// Carrier between the port logic and its burst storage.
// Assumes both ends are built with the same data and address widths.
`timescale 1ns/100ps

interface mem_if #(
  parameter int DATA_W = 36,
  parameter int AW     = 18,
  parameter int LANES  = 4
);
  import burst_pkg::*;
  logic                             wrEn;
  logic [AW-1:0]                    wrAddr;
  beat_t                            wrBeat;
  logic [DATA_W-1:0]                wrData;
  logic [LANES-1:0]                 wrLaneEn;
  logic [AW-1:0]                    rdAddr;
  logic [`BURST_LEN-1:0][DATA_W-1:0] rdWords;

  modport ctrl  (output wrEn, wrAddr, wrBeat, wrData, wrLaneEn, rdAddr,
                 input  rdWords);
  modport store (input  wrEn, wrAddr, wrBeat, wrData, wrLaneEn, rdAddr,
                 output rdWords);
endinterface : mem_if

//--- rtl/pin_sampler.sv
// Three-stage sampler for pins from outside the core clock domain.
// Assumes a level counts only once stages two and three agree.
`timescale 1ns/100ps

module pin_sampler #(
  parameter int               WIDTH     = 8,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
)(
  input  wire logic             core_clk, // Core clock
  input  wire logic             rstn,     // Async reset, active low
  input  wire logic [WIDTH-1:0] pinIn,    // Raw pins
  output wire logic [WIDTH-1:0] levelOut  // Agreed level
);
  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage3_reg;
  logic [WIDTH-1:0] level_reg;
  logic [WIDTH-1:0] differ;

  assign differ   = stage2_reg ^ stage3_reg;
  assign levelOut = level_reg;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      stage1_reg <= RESET_VAL;
      stage2_reg <= RESET_VAL;
      stage3_reg <= RESET_VAL;
    end else begin
      stage1_reg <= pinIn;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  // Bits in disagreement keep their previous level
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      level_reg <= RESET_VAL;
    end else begin
      level_reg <= (stage2_reg & ~differ) | (level_reg & differ);
    end
  end
endmodule : pin_sampler

//--- rtl/burst_array.sv
// Burst storage: four words per row, lane-masked writes, flop based.
// Assumes only the low STORE_AW row bits select a row.
`timescale 1ns/100ps

module burst_array #(
  parameter int DATA_W   = 36,
  parameter int LANE_W   = 9,
  parameter int STORE_AW = 4
)(
  input wire logic core_clk, // Core clock
  input wire logic rstn,     // Reset, used by checks only
  mem_if.store     mem       // Port logic side
);
  import burst_pkg::*;
  localparam int IDX_W = STORE_AW + `BEAT_W;
  localparam int WORDS = 2 ** IDX_W;

  logic [DATA_W-1:0] store_reg [WORDS];
  logic [IDX_W-1:0]  wrIdx;

  assign wrIdx = {mem.wrAddr[STORE_AW-1:0], mem.wrBeat};

  // Lanes with a low enable keep their old contents
  always_ff @(posedge core_clk) begin
    if (mem.wrEn) begin
      for (int b = 0; b < DATA_W; b++) begin
        if (mem.wrLaneEn[b / LANE_W]) begin
          store_reg[wrIdx][b] <= mem.wrData[b];
        end
      end
    end
  end

  always_comb begin
    for (int w = 0; w < `BURST_LEN; w++) begin
      mem.rdWords[w] = store_reg[{mem.rdAddr[STORE_AW-1:0],
                                  beat_t'(w)}];
    end
  end

  masked_lane_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    mem.wrEn && !mem.wrLaneEn[0]
      |=> store_reg[$past(wrIdx)][LANE_W-1:0] ==
          $past(store_reg[wrIdx][LANE_W-1:0]))
    else $error("Masked lane was overwritten");
endmodule : burst_array

//--- rtl/quad_rate_sram_burst4_port.sv
// Pin-level port logic of a double-rate burst memory with split ports.
// Assumes link clocks far slower than core_clk, sampled as plain pins.
`timescale 1ns/100ps

// Overview of operation
// - Write data taken on both input clock edges
// - Low write select at input rise starts write
// - High write select ignores write data
// - Nibble selects gate low and high nibbles
// - Byte selects gate nine-bit data lanes
// - Deselected lane keeps its stored contents
// - Selects sampled on same edge as data
// - One shared address bus for both ports
// - One array of four-word rows, address width set by data
// - Address ignored when its port deselected
// - Read data launched on output clock edges, on input clock edges in single clock mode
// - Deselected read port floats its data bus
// - Low read select at input rise starts read
// - Pending read finishes, then bus floats
// - Every read returns four sequential words
// - Accesses start only at input positive rise
// - Bypass low selects one-cycle read latency
// - Free-running echo clock follows output clock, input clock in single clock mode
module quad_rate_sram_burst4_port #(
  parameter  int DATA_W   = 36,
  parameter  int STORE_AW = `STORE_AW,
  localparam int AW       = burst_pkg::addr_w(DATA_W),
  localparam int LANES    = burst_pkg::lane_count(DATA_W)
)(
  input  wire logic                     core_clk,        // Core clock
  input  wire logic                     rstn,            // Reset, low
  input  wire logic                     inputTimingPos,  // Input clock
  input  wire logic                     inputTimingNeg,  // Its inverse
  input  wire logic                     outputTimingPos, // Output clock
  input  wire logic                     outputTimingNeg, // Its inverse
  input  wire logic                     singleClockMode, // Strap, high
  input  wire logic                     pllBypassN,      // Bypass, low
  input  wire logic                     writePortSelN,   // Write, low
  input  wire logic                     readPortSelN,    // Read, low
  input  wire logic [AW-1:0]            rowPointer,      // Burst address
  input  wire logic [DATA_W-1:0]        writeBusIn,      // Write data
  input  wire logic [`NIBBLE_SEL_W-1:0] nibbleWriteSelN, // Nibble masks
  input  wire logic [`BYTE_SEL_W-1:0]   byteWriteSelN,   // Byte masks
  output wire logic [DATA_W-1:0]        readBusOut,      // Read data
  output wire logic                     readBusOe,       // Drive enable
  output wire logic                     echoTimingPos,   // Echo clock
  output wire logic                     echoTimingNeg    // Its inverse
);
  import burst_pkg::*;
  localparam int SAMP_W = AW + LANES + DATA_W;

  logic [`CTL_W-1:0] ctlRaw;
  logic [`CTL_W-1:0] ctlS;
  logic [LANES-1:0]  laneSelRaw;
  logic [SAMP_W-1:0] datS;
  logic [`CLK_W-1:0] prevClk_reg;
  logic              kRise;
  logic              knRise;
  logic              cRise;
  logic              cnRise;
  logic              outPosEdge;
  logic              outNegEdge;
  logic              outEdge;
  logic              single;
  logic              wselS;
  logic              rselS;
  logic [DATA_W-1:0] wrDataS;
  logic [LANES-1:0]  laneSelS;
  logic [AW-1:0]     addrS;

  mem_if #(.DATA_W(DATA_W), .AW(AW), .LANES(LANES)) mem ();

  // Nibble masks serve the eight-bit build, byte masks all others
  generate
    if (DATA_W == `NIBBLE_DATA_W) begin : g_nibble
      assign laneSelRaw = nibbleWriteSelN;
    end else begin : g_byte
      assign laneSelRaw = byteWriteSelN[LANES-1:0];
    end
  endgenerate

  assign ctlRaw = {singleClockMode, pllBypassN, readPortSelN,
                   writePortSelN, outputTimingNeg, outputTimingPos,
                   inputTimingNeg, inputTimingPos};

  pin_sampler #(.WIDTH(`CTL_W), .RESET_VAL(`CTL_RESET)) ctl_sampler (
    .core_clk (core_clk),
    .rstn     (rstn),
    .pinIn    (ctlRaw),
    .levelOut (ctlS)
  );

  // Same depth as the clocks, so each beat lines up with its edge
  pin_sampler #(.WIDTH(SAMP_W)) data_sampler (
    .core_clk (core_clk),
    .rstn     (rstn),
    .pinIn    ({rowPointer, laneSelRaw, writeBusIn}),
    .levelOut (datS)
  );

  burst_array #(
    .DATA_W   (DATA_W),
    .LANE_W   (lane_w(DATA_W)),
    .STORE_AW (STORE_AW)
  ) array (
    .core_clk (core_clk),
    .rstn     (rstn),
    .mem      (mem.store)
  );

  assign wrDataS  = datS[DATA_W-1:0];
  assign laneSelS = datS[DATA_W+LANES-1:DATA_W];
  assign addrS    = datS[SAMP_W-1:DATA_W+LANES];
  assign wselS    = ctlS[`BIT_WSEL];
  assign rselS    = ctlS[`BIT_RSEL];
  assign single   = ctlS[`BIT_SINGLE];

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      prevClk_reg <= `CLK_RESET;
    end else begin
      prevClk_reg <= ctlS[`CLK_W-1:0];
    end
  end

  assign kRise  = ctlS[`BIT_KP] & ~prevClk_reg[`BIT_KP];
  assign knRise = ctlS[`BIT_KN] & ~prevClk_reg[`BIT_KN];
  assign cRise  = ctlS[`BIT_CP] & ~prevClk_reg[`BIT_CP];
  assign cnRise = ctlS[`BIT_CN] & ~prevClk_reg[`BIT_CN];
  // Single clock mode launches read data on the input pair
  assign outPosEdge = single ? kRise : cRise;
  assign outNegEdge = single ? knRise : cnRise;
  assign outEdge    = outPosEdge | outNegEdge;

  // Write burst
  wr_state_e     wrState_reg;
  wr_state_e     wrState_next;
  logic [AW-1:0] wrAddr_reg;
  logic          wrFire;

  always_comb begin
    wrFire       = 1'b0;
    wrState_next = wrState_reg;
    unique case (wrState_reg)
      WR_IDLE: begin
        wrFire       = kRise & ~wselS;
        wrState_next = wrFire ? WR_BEAT1 : WR_IDLE;
      end
      WR_BEAT1: begin
        wrFire       = knRise;
        wrState_next = wrFire ? WR_BEAT2 : WR_BEAT1;
      end
      WR_BEAT2: begin
        wrFire       = kRise;
        wrState_next = wrFire ? WR_BEAT3 : WR_BEAT2;
      end
      WR_BEAT3: begin
        wrFire       = knRise;
        wrState_next = wrFire ? WR_IDLE : WR_BEAT3;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wrState_reg <= WR_IDLE;
    end else begin
      wrState_reg <= wrState_next;
    end
  end

  // Address kept only from a selected start edge
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wrAddr_reg <= '0;
    end else if (wrState_reg == WR_IDLE && wrFire) begin
      wrAddr_reg <= addrS;
    end
  end

  assign mem.wrEn     = wrFire;
  assign mem.wrAddr   = (wrState_reg == WR_IDLE) ? addrS : wrAddr_reg;
  assign mem.wrBeat   = beat_t'(wrState_reg);
  assign mem.wrData   = wrDataS;
  assign mem.wrLaneEn = ~laneSelS;

  // Read request and latency
  logic                  rdReq;
  logic                  pendValid_reg;
  logic [`LAT_CNT_W-1:0] pendCnt_reg;
  logic [AW-1:0]         pendAddr_reg;
  logic                  startBurst;

  assign rdReq      = kRise & ~rselS;
  assign startBurst = outEdge & pendValid_reg & (pendCnt_reg == '0);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pendValid_reg <= 1'b0;
      pendCnt_reg   <= '0;
      pendAddr_reg  <= '0;
    end else begin
      if (startBurst) begin
        pendValid_reg <= 1'b0;
      end else if (outEdge && pendValid_reg) begin
        pendCnt_reg <= pendCnt_reg - `LAT_CNT_ONE;
      end
      // A new request wins over the edge it lands on
      if (rdReq) begin
        pendValid_reg <= 1'b1;
        pendAddr_reg  <= addrS;
        pendCnt_reg   <= (ctlS[`BIT_PLLN] ? `LAT_PLL_EDGES
                                          : `LAT_BYPASS_EDGES)
                         - `LAT_CNT_ONE;
      end
    end
  end

  assign mem.rdAddr = pendAddr_reg;

  // Read burst output
  out_state_e                         outState_reg;
  beat_t                              beatIdx_reg;
  logic [`BURST_LEN-1:0][DATA_W-1:0]  words_reg;
  logic [DATA_W-1:0]                  readBusOut_reg;
  logic                               readBusOe_reg;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      outState_reg   <= OUT_IDLE;
      beatIdx_reg    <= `BEAT_FIRST;
      words_reg      <= '0;
      readBusOut_reg <= '0;
      readBusOe_reg  <= 1'b0;
    end else begin
      unique case (outState_reg)
        OUT_IDLE, OUT_HOLD: begin
          if (startBurst) begin
            words_reg      <= mem.rdWords;
            readBusOut_reg <= mem.rdWords[`BEAT_FIRST];
            readBusOe_reg  <= 1'b1;
            beatIdx_reg    <= `BEAT_SECOND;
            outState_reg   <= OUT_DRIVE;
          end else if (outState_reg == OUT_HOLD && outPosEdge) begin
            readBusOe_reg <= 1'b0;
            outState_reg  <= OUT_IDLE;
          end
        end
        OUT_DRIVE: begin
          if (outEdge) begin
            readBusOut_reg <= words_reg[beatIdx_reg];
            beatIdx_reg    <= beatIdx_reg + `BEAT_SECOND;
            if (beatIdx_reg == `BEAT_LAST) begin
              outState_reg <= OUT_HOLD;
            end
          end
        end
      endcase
    end
  end

  // Echo clock
  logic echoPos_reg;
  logic echoNeg_reg;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      echoPos_reg <= 1'b0;
      echoNeg_reg <= 1'b0;
    end else begin
      echoPos_reg <= single ? ctlS[`BIT_KP] : ctlS[`BIT_CP];
      echoNeg_reg <= single ? ctlS[`BIT_KN] : ctlS[`BIT_CN];
    end
  end

  assign readBusOut    = readBusOut_reg;
  assign readBusOe     = readBusOe_reg;
  assign echoTimingPos = echoPos_reg;
  assign echoTimingNeg = echoNeg_reg;

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  write_start_a: assert property (
    kRise && !wselS && wrState_reg == WR_IDLE |=> wrState_reg == WR_BEAT1)
    else $error("Selected write did not start");
  write_deselect_a: assert property (
    kRise && wselS && wrState_reg == WR_IDLE |=> wrState_reg == WR_IDLE)
    else $error("Deselected write started");
  write_edge_a: assert property (
    wrState_reg == WR_BEAT1 && $past(wrState_reg) == WR_IDLE
      |-> $past(kRise))
    else $error("Write began off the input rise");
  write_beats_a: assert property (
    wrState_reg == WR_BEAT1 && knRise |-> mem.wrEn &&
      mem.wrBeat == `BEAT_SECOND && mem.wrAddr == wrAddr_reg)
    else $error("Negative edge beat not written");
  lane_mask_a: assert property (
    mem.wrEn |-> mem.wrLaneEn == ~laneSelS && mem.wrData == wrDataS)
    else $error("Lane select not aligned with beat");
  addr_hold_a: assert property (
    $changed(wrAddr_reg) |-> $past(kRise && !wselS))
    else $error("Write address taken while deselected");
  read_latency_a: assert property (
    rdReq && !readBusOe_reg |-> ##[1:60] readBusOe_reg)
    else $error("Read burst did not appear");
  bypass_count_a: assert property (
    rdReq && !ctlS[`BIT_PLLN] |=> pendCnt_reg == `LAT_CNT_ONE)
    else $error("Bypass latency wrong");
  burst_four_a: assert property (
    outState_reg == OUT_HOLD && $past(outState_reg) == OUT_DRIVE
      |-> $past(beatIdx_reg) == `BEAT_LAST && readBusOe_reg)
    else $error("Burst was not four beats");
  float_after_a: assert property (
    outState_reg == OUT_HOLD && outPosEdge && !startBurst
      |=> !readBusOe_reg)
    else $error("Bus still driven after burst");
  idle_float_a: assert property (
    outState_reg == OUT_IDLE |-> !readBusOe_reg)
    else $error("Bus driven while idle");
  echo_follow_a: assert property (
    ##1 echoTimingPos == $past(single ? ctlS[`BIT_KP] : ctlS[`BIT_CP]))
    else $error("Echo clock does not follow");
  launch_edge_a: assert property (
    $changed(readBusOut_reg) |-> $past(outEdge))
    else $error("Read data moved off a launch edge");

  write_burst_c: cover property (
    wrState_reg == WR_BEAT3 && knRise);
  read_burst_c: cover property (
    outState_reg == OUT_DRIVE ##[1:80] outState_reg == OUT_HOLD);
  back_to_back_c: cover property (
    outState_reg == OUT_HOLD && startBurst);
  masked_write_c: cover property (
    mem.wrEn && mem.wrLaneEn != '1);
endmodule : quad_rate_sram_burst4_port

//--- verification/ctrl_model.sv
// Controller model: link clock pairs and four-beat burst requests.
// Assumes core_clk comes from the bench; pins move on its falling edge.
`timescale 1ns/100ps

module ctrl_model #(
  parameter int DW = 36,
  parameter int AW = 18
)(
  input  wire logic          core_clk, // Bench clock
  input  wire logic          cRun,     // Output clocks run
  output logic               kPos,     // Input clock
  output logic               kNeg,     // Its inverse
  output logic               cPos,     // Output clock
  output logic               cNeg,     // Its inverse
  output logic               wrSelN,   // Write select
  output logic               rdSelN,   // Read select
  output logic [AW-1:0]      addr,     // Shared address
  output logic [DW-1:0]      wData,    // Write data
  output logic [3:0]         byteN,    // Lane masks
  output logic [1:0]         nibN,     // Nibble masks
  output logic [2:0]         phase,    // Core cycle within link period
  output int                 edgeIdx   // Input clock edges so far
);
  logic busy;

  initial begin
    {kPos, kNeg, cPos, cNeg} = 4'h5;
    {wrSelN, rdSelN, busy} = 3'h6;
    {addr, wData, byteN, nibN} = '1;
    phase = 3'h7;
    edgeIdx = -1;
  end

  // Clock edges every four core cycles, a 200 ns link period
  always @(negedge core_clk) begin
    phase <= phase + 3'h1;
    if (phase[1:0] == 2'h3) begin
      kPos    <= phase[2];
      kNeg    <= !phase[2];
      cPos    <= cRun && phase[2];
      cNeg    <= !(cRun && phase[2]);
      edgeIdx <= edgeIdx + 1;
    end
    if (!busy && phase == 3'h5) begin
      // Released lines carry a fresh pattern
      addr  <= AW'($urandom());
      wData <= DW'({$urandom(), $urandom()});
      {byteN, nibN} <= 6'($urandom());
    end
  end

  task automatic burst(input logic doWr, input logic [AW-1:0] wAddr,
                       input logic [3:0][DW-1:0] wd,
                       input logic [3:0][3:0] wm, input logic doRd,
                       input logic [AW-1:0] rAddr, output int rdEdge);
    busy = 1'b1;
    for (int b = 0; b < 4; b++) begin
      @(negedge core_clk iff phase == (b[0] ? 3'h1 : 3'h5));
      if (b == 0) begin
        rdEdge = edgeIdx + (doWr ? 3 : 1);
      end
      wrSelN <= !(doWr && b == 0);
      rdSelN <= !(doRd && b == (doWr ? 2 : 0));
      addr   <= (doWr && b == 0) ? wAddr :
                (doRd && b == 2) ? rAddr :
                (b == 0) ? rAddr : AW'($urandom());
      wData  <= wd[b];
      byteN  <= wm[b];
      nibN   <= wm[b][1:0];
    end
    @(negedge core_clk iff phase == 3'h3);
    busy = 1'b0;
  endtask : burst
endmodule : ctrl_model

//--- verification/tb_top.sv
// Bench for the burst memory port: model drives pins, queue checks reads.
// Assumes the design files and ctrl_model are compiled ahead of it.
`timescale 1ns/100ps

module tb_top;
  import burst_pkg::*;
  localparam int DW = 36;
  localparam int AW = 18;

  typedef struct {
    int            e;
    logic          oe;
    logic [DW-1:0] d;
  } beat_s;

  logic          core_clk, rstn, singleClockMode, pllBypassN, cRun;
  logic          kPos, kNeg, cPos, cNeg, wrSelN, rdSelN;
  logic          readBusOe, echoPos, echoNeg;
  logic [AW-1:0] addr;
  logic [DW-1:0] wData, readBusOut;
  logic [3:0]    byteN;
  logic [1:0]    nibN;
  logic [2:0]    phase;
  int            edgeIdx, errors, total_checks;
  logic [DW-1:0] shadow [16][4];
  beat_s         expQ[$];
  beat_s         nxt;

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  quad_rate_sram_burst4_port #(.DATA_W(DW)) quad_rate_sram_burst4_port_inst (
    .core_clk(core_clk), .rstn(rstn), .inputTimingPos(kPos),
    .inputTimingNeg(kNeg), .outputTimingPos(cPos), .outputTimingNeg(cNeg),
    .singleClockMode(singleClockMode), .pllBypassN(pllBypassN),
    .writePortSelN(wrSelN), .readPortSelN(rdSelN), .rowPointer(addr),
    .writeBusIn(wData), .nibbleWriteSelN(nibN), .byteWriteSelN(byteN),
    .readBusOut(readBusOut), .readBusOe(readBusOe),
    .echoTimingPos(echoPos), .echoTimingNeg(echoNeg));

  ctrl_model #(.DW(DW), .AW(AW)) ctrl_model_inst (
    .core_clk(core_clk), .cRun(cRun), .kPos(kPos), .kNeg(kNeg),
    .cPos(cPos), .cNeg(cNeg), .wrSelN(wrSelN), .rdSelN(rdSelN),
    .addr(addr), .wData(wData), .byteN(byteN), .nibN(nibN),
    .phase(phase), .edgeIdx(edgeIdx));

  task automatic check(input logic [DW:0] got, input logic [DW:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic complete_run;
    $display("Checks %0d, errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run

  // One burst slot: optional write, optional read, notes expected beats
  task automatic op(input logic doWr, input logic [3:0] wRow,
                    input logic full, input logic doRd,
                    input logic [3:0] rRow, input logic last);
    logic [3:0][DW-1:0] wd;
    logic [3:0][3:0]    wm;
    int                 e;
    int                 lat;
    lat = pllBypassN ? 3 : 2;
    for (int b = 0; b < 4; b++) begin
      wd[b] = DW'({$urandom(), $urandom()});
      wm[b] = full ? 4'h0 : 4'($urandom());
    end
    ctrl_model_inst.burst(doWr, {14'($urandom()), wRow}, wd, wm, doRd,
                          {14'($urandom()), rRow}, e);
    for (int b = 0; b < 4; b++) begin
      if (doRd) begin
        expQ.push_back(beat_s'{e + lat + b, 1'b1, shadow[rRow][b]});
      end
      for (int l = 0; l < 4; l++) begin
        if (doWr && !wm[b][l]) begin
          shadow[wRow][b][l*9 +: 9] = wd[b][l*9 +: 9];
        end
      end
    end
    if (doRd && last) begin
      expQ.push_back(beat_s'{e + 2 * lat + 2, 1'b0, '0});
    end
  endtask : op

  // Each output edge is judged six and a half core cycles after it
  always @(posedge core_clk) begin
    if (rstn && phase[1:0] == 2'h2 && edgeIdx > 4) begin
      check(37'({echoPos, echoNeg}), 37'({edgeIdx[0], !edgeIdx[0]}));
      if (expQ.size() > 0 && expQ[0].e < edgeIdx) begin
        nxt = expQ.pop_front();
        check(37'(edgeIdx - 1), 37'(nxt.e));
        check({readBusOe, nxt.oe ? readBusOut : '0}, {nxt.oe,nxt.d});
      end
    end
  end

  initial begin
    void'($urandom(44652));
    {rstn, singleClockMode, pllBypassN, cRun} = 4'h6;
    errors = 0;
    total_checks = 0;
    repeat (2) @(negedge core_clk);
    rstn = 1'b1;
    repeat (16) @(negedge core_clk);
    // Fill every row, all lanes written
    for (int r = 0; r < 16; r++)
      op(1'b1, 4'(r), 1'b1, 1'b0, 4'h0, 1'b0);
    // Back-to-back reads, single clock mode, output clocks still
    for (int r = 0; r < 16; r++)
      op(1'b0, 4'h0, 1'b0, 1'b1, 4'(r), r == 15);
    // Masked writes overlapped by reads of other rows
    for (int r = 0; r < 16; r++)
      op(1'b1, 4'(r), 1'b0, 1'b1, 4'(r + 8), r == 15);
    repeat (32) @(negedge core_clk);
    cRun = 1'b1;
    repeat (16) @(negedge core_clk);
    singleClockMode = 1'b0;
    pllBypassN = 1'b0;
    repeat (16) @(negedge core_clk);
    // Short latency with the loop bypassed
    for (int r = 0; r < 16; r++)
      op(1'b0, 4'h0, 1'b0, 1'b1, 4'(r), r == 15);
    repeat (32) @(negedge core_clk);
    pllBypassN = 1'b1;
    repeat (16) @(negedge core_clk);
    // Separate output clocks with the loop on
    for (int r = 0; r < 4; r++)
      op(1'b0, 4'h0, 1'b0, 1'b1, 4'(r), r == 3);
    repeat (48) @(negedge core_clk);
    check(37'(expQ.size()), 37'h0);
    complete_run();
  end

  initial begin
    #200000;
    errors++;
    complete_run();
  end
endmodule : tb_top
